//--- tcw_timer.sv
// top: 8-bit timer compare and waveform unit with an ahb-lite register port
// Function
// - buffered mode writes go to buffer; otherwise straight to live compare
// - buffer copies into live compare only at the count's bottom point
// - force strobe acts like a match on output only, non-pwm modes
// - counter write blocks any compare match in the next timer tick
// - output state keeps its value across waveform mode changes
// - output action changes take effect at once, not buffered
// - output action sets match behaviour and takes over the pin
// - pin shows output state only when its direction is output
// - normal mode counts up, wraps 0xFF to 0x00, writable anytime
// - normal mode sets overflow flag as counter becomes zero
// - clear-on-compare counts to compare value then clears to zero
// - clear-on-compare compare writes unbuffered; missed match waits for wrap
// - clear-on-compare toggle action flips output on every match
// - clear-on-compare sets overflow flag on roll from max to zero
// - fast pwm counts bottom to max, clears on next tick
// - fast pwm action 2 non-inverting, action 3 inverting
// - fast pwm bottom update happens on max-to-bottom tick
// - fast pwm sets overflow flag each time counter rolls from max to bottom
// - compare at bottom gives spike; at max gives constant level
// - fast pwm toggle gives 50% duty, compare stays buffered
// - compare double buffering only in pwm modes
// - bottom is zero, max is 0xFF, top depends on mode
// - match sets compare flag at the next timer tick
// - software counter write beats hardware clear or count
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module tcw_timer (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // timer clock enable from the prescaler
    input  wire logic        timer_tick,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // compare output pin
    output logic             compare_output_o,
    output logic             compare_output_oe
);
    // ==================================================================
    // bus front end
    logic       wr_q;
    logic       rd_q;
    logic [7:0] addr_q;
    tcw_ahb_slave u_bus (
        .clock   (clock),
        .reset_n (reset_n),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hready  (hready),
        .wr_q    (wr_q),
        .rd_q    (rd_q),
        .addr_q  (addr_q)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp;
    logic wr_flags;
    logic wr_pin;
    assign wr_ctrl  = wr_q & hit(addr_q, tcw_pkg::OFF_CTRL);
    assign wr_count = wr_q & hit(addr_q, tcw_pkg::OFF_COUNT);
    assign wr_cmp   = wr_q & hit(addr_q, tcw_pkg::OFF_COMPARE);
    assign wr_flags = wr_q & hit(addr_q, tcw_pkg::OFF_FLAGS);
    assign wr_pin   = wr_q & hit(addr_q, tcw_pkg::OFF_PIN);

    // ==================================================================
    // control register
    tcw_pkg::tcw_mode_t   mode_q;
    tcw_pkg::tcw_action_t action_q;
    logic                 tick_en_q;
    logic                 pwm_mode;
    assign pwm_mode = mode_q[0];
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mode_q    <= tcw_pkg::MODE_NORMAL;
            action_q  <= tcw_pkg::ACT_OFF;
            tick_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            mode_q    <= tcw_pkg::tcw_mode_t'(
                hwdata[tcw_pkg::CTRL_MODE_LO +: 2]);
            // no buffering: the new action is used from the next edge
            action_q  <= tcw_pkg::tcw_action_t'(
                hwdata[tcw_pkg::CTRL_ACTION_LO +: 2]);
            tick_en_q <= hwdata[tcw_pkg::CTRL_TICK_BIT];
        end
    end

    // force strobe is never stored; it reads back as zero
    tcw_pkg::tcw_action_t action_now;
    logic                 force_ev;
    assign action_now = wr_ctrl ? tcw_pkg::tcw_action_t'(
        hwdata[tcw_pkg::CTRL_ACTION_LO +: 2]) : action_q;
    assign force_ev = wr_ctrl & hwdata[tcw_pkg::CTRL_FORCE_BIT]
                      & ~hwdata[tcw_pkg::CTRL_MODE_LO];

    // ==================================================================
    // timer tick: no ticks when no clock source is enabled
    logic tick;
    assign tick = timer_tick & tick_en_q;

    // ==================================================================
    // counter and write blocking
    logic [7:0] count_q;
    logic [7:0] live_cmp_q;
    logic [7:0] buf_cmp_q;
    logic       block_q;
    logic       equal;
    logic       match;
    logic       at_max;
    logic       clear_hit;
    assign equal  = (count_q == live_cmp_q);
    assign match  = equal & ~block_q;
    assign at_max = (count_q == tcw_pkg::CNT_MAX);
    // phase-correct mode is not supported; it behaves as normal counting
    assign clear_hit = (mode_q == tcw_pkg::MODE_CLEAR) & match;

    always_ff @(posedge clock) begin
        if (!reset_n)
            count_q <= tcw_pkg::RST_BYTE;
        else if (wr_count)
            count_q <= hwdata[7:0];
        else if (tick) begin
            if (clear_hit)
                count_q <= tcw_pkg::CNT_BOTTOM;
            else
                count_q <= count_q + 8'h01;
        end
    end

    // block lasts until the next timer tick has passed, even if stopped
    always_ff @(posedge clock) begin
        if (!reset_n)
            block_q <= 1'b0;
        else if (wr_count)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end

    // ==================================================================
    // compare value with optional double buffer
    logic wrap_tick;
    assign wrap_tick = tick & ~wr_count & at_max;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            live_cmp_q <= tcw_pkg::RST_BYTE;
            buf_cmp_q  <= tcw_pkg::RST_BYTE;
        end else begin
            if (wr_cmp)
                buf_cmp_q <= hwdata[7:0];
            if (wr_cmp && !pwm_mode)
                live_cmp_q <= hwdata[7:0];
            else if (pwm_mode && wrap_tick)
                live_cmp_q <= buf_cmp_q;
        end
    end

    // ==================================================================
    // flags: set wins over a software clear in the same cycle
    logic cmp_flag_q;
    logic ovf_flag_q;
    logic ovf_set;
    assign ovf_set = tick & ~wr_count & (mode_q == tcw_pkg::MODE_FAST
        ? at_max
        : (at_max | clear_hit) & ~(clear_hit & ~at_max));
    always_ff @(posedge clock) begin
        if (!reset_n)
            cmp_flag_q <= 1'b0;
        else if (tick && match && !wr_count)
            cmp_flag_q <= 1'b1;
        else if (wr_flags && hwdata[tcw_pkg::FLAG_CMP_BIT])
            cmp_flag_q <= 1'b0;
    end
    always_ff @(posedge clock) begin
        if (!reset_n)
            ovf_flag_q <= 1'b0;
        else if (ovf_set)
            ovf_flag_q <= 1'b1;
        else if (wr_flags && hwdata[tcw_pkg::FLAG_OVF_BIT])
            ovf_flag_q <= 1'b0;
    end

    // ==================================================================
    // output stage
    tcw_cmp_if cmp ();
    assign cmp.match_ev  = tick & match & ~wr_count;
    assign cmp.bottom_ev = wrap_tick;
    assign cmp.force_ev  = force_ev;
    assign cmp.mode      = mode_q;
    assign cmp.action    = action_now;
    tcw_out_stage u_out (
        .clock   (clock),
        .reset_n (reset_n),
        .cmp     (cmp)
    );

    // ==================================================================
    // pin register: direction and port data
    logic dir_q;
    logic port_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dir_q  <= 1'b0;
            port_q <= 1'b0;
        end else if (wr_pin) begin
            dir_q  <= hwdata[tcw_pkg::PIN_DIR_BIT];
            port_q <= hwdata[tcw_pkg::PIN_PORT_BIT];
        end
    end

    // pin registered: one cycle behind the internal state
    logic pin_d;
    assign pin_d = (action_q != tcw_pkg::ACT_OFF) ? cmp.state
                                                  : port_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            compare_output_o  <= 1'b0;
            compare_output_oe <= 1'b0;
        end else begin
            compare_output_o  <= pin_d;
            compare_output_oe <= dir_q;
        end
    end

    // ==================================================================
    // read data and response; zero wait, always okay
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (addr_q)
            tcw_pkg::OFF_CTRL: begin
                rdata_d[tcw_pkg::CTRL_MODE_LO +: 2]   = mode_q;
                rdata_d[tcw_pkg::CTRL_ACTION_LO +: 2] = action_q;
                rdata_d[tcw_pkg::CTRL_TICK_BIT]       = tick_en_q;
            end
            tcw_pkg::OFF_COUNT:   rdata_d[7:0] = count_q;
            tcw_pkg::OFF_COMPARE: rdata_d[7:0] = pwm_mode ? buf_cmp_q
                                                          : live_cmp_q;
            tcw_pkg::OFF_FLAGS: begin
                rdata_d[tcw_pkg::FLAG_CMP_BIT] = cmp_flag_q;
                rdata_d[tcw_pkg::FLAG_OVF_BIT] = ovf_flag_q;
            end
            tcw_pkg::OFF_PIN: begin
                rdata_d[tcw_pkg::PIN_DIR_BIT]   = dir_q;
                rdata_d[tcw_pkg::PIN_PORT_BIT]  = port_q;
                rdata_d[tcw_pkg::PIN_STATE_BIT] = cmp.state;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end
    assign hrdata    = rd_q ? rdata_d : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==================================================================
    // checks
    block_match_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_count |=> !cmp_flag_q || $past(cmp_flag_q))
        else $error("match not blocked after counter write");
    cmp_flag_set_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick && equal && !block_q && !wr_count |=> cmp_flag_q)
        else $error("compare flag not set after match");
    normal_wrap_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick && !wr_count && at_max && mode_q == tcw_pkg::MODE_NORMAL
        |=> count_q == tcw_pkg::CNT_BOTTOM && ovf_flag_q)
        else $error("normal mode wrap or overflow flag wrong");
    ctc_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick && !wr_count && clear_hit |=> count_q == tcw_pkg::CNT_BOTTOM)
        else $error("clear-on-compare did not clear");
    force_no_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
        force_ev && !tick && !cmp_flag_q |=> !cmp_flag_q)
        else $error("force strobe set the compare flag");
    no_tick_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !tick && !wr_count |=> $stable(count_q))
        else $error("counter moved without a timer tick");
    buffer_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        pwm_mode && !wrap_tick && !wr_ctrl |=> $stable(live_cmp_q))
        else $error("live compare changed away from bottom");
    fast_ovf_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick && !wr_count && at_max && mode_q == tcw_pkg::MODE_FAST
        |=> ovf_flag_q ##0 count_q == tcw_pkg::CNT_BOTTOM)
        else $error("fast pwm max handling wrong");
    pin_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
        1'b1 |=> compare_output_oe == $past(dir_q))
        else $error("pin enable does not follow direction");
    write_wins_a: assert property (@(posedge clock)
        disable iff (!reset_n) wr_count |=> count_q == $past(hwdata[7:0]))
        else $error("counter write lost");
    block_clear_a: assert property (@(posedge clock)
        disable iff (!reset_n) block_q && tick && !wr_count |=> !block_q)
        else $error("match block outlived its tick");
    direct_cmp_a: assert property (@(posedge clock)
        disable iff (!reset_n) wr_cmp && !pwm_mode
        |=> live_cmp_q == $past(hwdata[7:0]))
        else $error("unbuffered compare write lost");
    buf_load_a: assert property (@(posedge clock)
        disable iff (!reset_n) pwm_mode && wrap_tick
        |=> live_cmp_q == $past(buf_cmp_q))
        else $error("buffer not loaded at bottom");
    ovf_sticky_a: assert property (@(posedge clock)
        disable iff (!reset_n) ovf_flag_q && !wr_flags |=> ovf_flag_q)
        else $error("overflow flag cleared by hardware");
    ctc_ovf_a: assert property (@(posedge clock)
        disable iff (!reset_n) mode_q == tcw_pkg::MODE_CLEAR && tick
        && !at_max && !ovf_flag_q |=> !ovf_flag_q)
        else $error("overflow flag set off the max roll");
    force_set_a: assert property (@(posedge clock)
        disable iff (!reset_n) force_ev && cmp.action == tcw_pkg::ACT_SET
        && mode_q != tcw_pkg::MODE_FAST |=> cmp.state)
        else $error("forced set did not set output state");
    force_count_a: assert property (@(posedge clock)
        disable iff (!reset_n) force_ev && !tick |=> $stable(count_q))
        else $error("force strobe moved the counter");
    pin_port_a: assert property (@(posedge clock)
        disable iff (!reset_n) action_q == tcw_pkg::ACT_OFF
        |=> compare_output_o == $past(port_q))
        else $error("pin not from port bit");
    pin_state_a: assert property (@(posedge clock)
        disable iff (!reset_n) action_q != tcw_pkg::ACT_OFF
        |=> compare_output_o == $past(cmp.state))
        else $error("pin not from output state");
    count_step_a: assert property (@(posedge clock)
        disable iff (!reset_n) tick && !wr_count && !clear_hit
        |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not step by one");
endmodule : tcw_timer

//--- tcw_pkg.sv
// package: register map, field layout and encodings for the compare unit
package tcw_pkg;
    // ==================================================================
    // register byte addresses
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_COUNT   = 8'h04;
    localparam logic [7:0] OFF_COMPARE = 8'h08;
    localparam logic [7:0] OFF_FLAGS   = 8'h0C;
    localparam logic [7:0] OFF_PIN     = 8'h10;
    // ==================================================================
    // control, flag and pin register fields
    localparam int CTRL_FORCE_BIT  = 7;
    localparam int CTRL_MODE_LO    = 0;
    localparam int CTRL_ACTION_LO  = 2;
    localparam int CTRL_TICK_BIT   = 4;
    localparam int FLAG_CMP_BIT    = 0;
    localparam int FLAG_OVF_BIT    = 1;
    localparam int PIN_DIR_BIT     = 0;
    localparam int PIN_PORT_BIT    = 1;
    localparam int PIN_STATE_BIT   = 2;
    // ==================================================================
    // counter landmarks and reset values
    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hFF;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    // ==================================================================
    // waveform modes and output actions
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PHASE  = 2'b01,
        MODE_CLEAR  = 2'b10,
        MODE_FAST   = 2'b11
    } tcw_mode_t;
    typedef enum logic [1:0] {
        ACT_OFF    = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_SET    = 2'b11
    } tcw_action_t;
endpackage : tcw_pkg

//--- tcw_cmp_if.sv
// interface: compare channel between the core and the output stage
`timescale 1ns/100ps
interface tcw_cmp_if;
    logic                 match_ev;
    logic                 bottom_ev;
    logic                 force_ev;
    tcw_pkg::tcw_mode_t   mode;
    tcw_pkg::tcw_action_t action;
    logic                 state;
    modport core (output match_ev, bottom_ev, force_ev, mode, action,
                  input state);
    modport outs (input match_ev, bottom_ev, force_ev, mode, action,
                  output state);
endinterface : tcw_cmp_if

//--- tcw_ahb_slave.sv
// ahb-lite slave front end: latches the address phase, one-wait-free
`timescale 1ns/100ps
module tcw_ahb_slave (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    // decoded data-phase strobes
    output logic             wr_q,
    output logic             rd_q,
    output logic [7:0]       addr_q
);
    // ==================================================================
    // address phase capture
    logic take;
    assign take = hsel & hready & htrans[1];
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q   <= take & hwrite;
            rd_q   <= take & ~hwrite;
            addr_q <= take ? {haddr[7:2], 2'b00} : addr_q;
        end
    end
endmodule : tcw_ahb_slave

//--- tcw_out_stage.sv
// output stage: internal compare output state register
`timescale 1ns/100ps
module tcw_out_stage (
    // clock and reset
    input  wire logic  clock,
    input  wire logic  reset_n,
    // compare channel
    tcw_cmp_if.outs    cmp
);
    // ==================================================================
    // state update; kept across mode changes
    logic state_q;
    logic state_d;
    always_comb begin
        state_d = state_q;
        if (cmp.match_ev || cmp.force_ev) begin
            unique case (cmp.action)
                tcw_pkg::ACT_OFF:    state_d = state_q;
                tcw_pkg::ACT_TOGGLE: state_d = ~state_q;
                tcw_pkg::ACT_CLEAR:  state_d = 1'b0;
                tcw_pkg::ACT_SET:    state_d = 1'b1;
            endcase
        end
        // a match at max beats bottom, so compare max holds one level
        if (cmp.bottom_ev && cmp.mode == tcw_pkg::MODE_FAST) begin
            if (cmp.action == tcw_pkg::ACT_CLEAR)
                state_d = ~(cmp.match_ev) ? 1'b1 : 1'b0;
            else if (cmp.action == tcw_pkg::ACT_SET)
                state_d = ~(cmp.match_ev) ? 1'b0 : 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n)
            state_q <= 1'b0;
        else
            state_q <= state_d;
    end
    assign cmp.state = state_q;

    // ==================================================================
    // checks
    toggle_on_match_a: assert property (@(posedge clock) disable iff (!reset_n)
        cmp.match_ev && !cmp.bottom_ev && cmp.action == tcw_pkg::ACT_TOGGLE
        |=> state_q != $past(state_q))
        else $error("toggle action did not toggle on match");
    hold_no_event_a: assert property (@(posedge clock) disable iff (!reset_n)
        !cmp.match_ev && !cmp.force_ev && !cmp.bottom_ev
        |=> $stable(state_q))
        else $error("output state moved without an event");
    fast_bottom_set_a: assert property (@(posedge clock) disable iff (!reset_n)
        cmp.bottom_ev && !cmp.match_ev && cmp.mode == tcw_pkg::MODE_FAST
        && cmp.action == tcw_pkg::ACT_CLEAR |=> state_q)
        else $error("non-inverting pwm not set at bottom");
endmodule : tcw_out_stage

//--- tcw_testbench.sv
// testbench: self-checking bench for the timer compare and waveform unit
`timescale 1ns/100ps
module testbench;
    // ==================================================================
    // signals
    logic        clock;
    logic        reset_n;
    logic        timer_tick;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin_o;
    logic        pin_oe;
    int          n_fail;
    int          num_checks;
    localparam logic [7:0] A_CTL = tcw_pkg::OFF_CTRL;
    localparam logic [7:0] A_CNT = tcw_pkg::OFF_COUNT;
    localparam logic [7:0] A_CMP = tcw_pkg::OFF_COMPARE;
    localparam logic [7:0] A_FLG = tcw_pkg::OFF_FLAGS;
    localparam logic [7:0] A_PIN = tcw_pkg::OFF_PIN;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    tcw_timer DUT (
        .clock(clock), .reset_n(reset_n), .timer_tick(timer_tick),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .compare_output_o(pin_o), .compare_output_oe(pin_oe));

    always #12.5 clock = ~clock;

    // ==================================================================
    // common tasks
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask : chk

    // no wait state assumed: loop until hready is seen high
    task automatic wait_ready;
        int guard;
        guard = 0;
        do begin
            @(posedge clock);
            guard++;
        end while (hready !== 1'b1 && guard < 16);
        if (guard >= 16) begin
            n_fail++;
            complete_run();
        end
    endtask : wait_ready

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        wait_ready();
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk($sformatf("reg_%h", a), e, r);
    endtask : rc

    // control word: force, action, mode, tick enable always on
    task automatic wctl(input logic f, input logic [1:0] act,
                        input logic [1:0] md);
        wr(A_CTL, {24'h0, f, 2'h0, 1'b1, act, md});
    endtask : wctl

    task automatic tick_n(input int n);
        @(posedge clock);
        timer_tick <= 1'b1;
        repeat (n) @(posedge clock);
        timer_tick <= 1'b0;
    endtask : tick_n

    // ==================================================================
    // scenarios
    task automatic t_reset;
        rc(A_CTL, 32'h0);
        rc(A_CNT, 32'h0);
        rc(A_CMP, 32'h0);
        rc(A_FLG, 32'h0);
        rc(A_PIN, 32'h0);
        wr(8'h14, 32'hFF);
        rc(8'h14, 32'h0);
        chk("pin_oe", 32'h0, {31'h0, pin_oe});
        $display("test reset done");
    endtask : t_reset

    task automatic t_normal;
        wctl(1'b0, 2'h0, 2'h0);
        wr(A_CMP, 32'h80);
        wr(A_CNT, 32'hFE);
        tick_n(1);
        rc(A_CNT, 32'hFF);
        rc(A_FLG, 32'h0);
        tick_n(1);
        rc(A_CNT, 32'h00);
        rc(A_FLG, 32'h2);
        wr(A_FLG, 32'h2);
        rc(A_FLG, 32'h0);
        repeat (4) @(posedge clock);
        rc(A_CNT, 32'h00);
        wr(A_CTL, 32'h0);
        tick_n(3);
        rc(A_CNT, 32'h00);
        $display("test normal done");
    endtask : t_normal

    task automatic t_ctc;
        wctl(1'b0, 2'h1, 2'h2);
        wr(A_CMP, 32'h03);
        wr(A_CNT, 32'h00);
        wr(A_FLG, 32'h3);
        tick_n(3);
        rc(A_CNT, 32'h03);
        rc(A_FLG, 32'h0);
        tick_n(1);
        rc(A_CNT, 32'h00);
        rc(A_FLG, 32'h1);
        rc(A_PIN, 32'h4);
        wr(A_CNT, 32'h05);
        wr(A_CMP, 32'h02);
        rc(A_CMP, 32'h02);
        wr(A_FLG, 32'h3);
        tick_n(250);
        rc(A_CNT, 32'hFF);
        rc(A_FLG, 32'h0);
        tick_n(1);
        rc(A_FLG, 32'h2);
        wr(A_FLG, 32'h3);
        tick_n(3);
        rc(A_CNT, 32'h00);
        rc(A_PIN, 32'h0);
        $display("test clear on compare done");
    endtask : t_ctc

    task automatic t_force;
        wr(A_FLG, 32'h3);
        wr(A_CNT, 32'h20);
        wctl(1'b1, 2'h1, 2'h0);
        rc(A_PIN, 32'h4);
        rc(A_FLG, 32'h0);
        rc(A_CTL, 32'h14);
        wctl(1'b1, 2'h2, 2'h0);
        rc(A_PIN, 32'h0);
        wctl(1'b1, 2'h3, 2'h2);
        rc(A_PIN, 32'h4);
        rc(A_CNT, 32'h20);
        wctl(1'b1, 2'h2, 2'h3);
        rc(A_PIN, 32'h4);
        wctl(1'b0, 2'h3, 2'h0);
        chk("pin_oe", 32'h0, {31'h0, pin_oe});
        wr(A_PIN, 32'h1);
        repeat (2) @(posedge clock);
        chk("pin_oe", 32'h1, {31'h0, pin_oe});
        chk("pin_o", 32'h1, {31'h0, pin_o});
        wctl(1'b0, 2'h0, 2'h0);
        repeat (2) @(posedge clock);
        chk("pin_o", 32'h0, {31'h0, pin_o});
        wr(A_PIN, 32'h3);
        repeat (2) @(posedge clock);
        chk("pin_o", 32'h1, {31'h0, pin_o});
        wr(A_PIN, 32'h2);
        repeat (2) @(posedge clock);
        chk("pin_oe", 32'h0, {31'h0, pin_oe});
        $display("test force and pin done");
    endtask : t_force

    task automatic t_block;
        wctl(1'b0, 2'h0, 2'h0);
        wr(A_CMP, 32'h10);
        wr(A_FLG, 32'h3);
        wr(A_CNT, 32'h10);
        tick_n(1);
        rc(A_CNT, 32'h11);
        rc(A_FLG, 32'h0);
        wr(A_CNT, 32'h0F);
        tick_n(2);
        rc(A_FLG, 32'h1);
        @(posedge clock);
        timer_tick <= 1'b1;
        wr(A_CNT, 32'h40);
        timer_tick <= 1'b0;
        rc(A_CNT, 32'h40);
        $display("test blocking done");
    endtask : t_block

    task automatic t_fast;
        wr(A_CMP, 32'h05);
        wctl(1'b0, 2'h2, 2'h3);
        wr(A_CMP, 32'h80);
        rc(A_CMP, 32'h80);
        wr(A_CNT, 32'h00);
        wr(A_FLG, 32'h3);
        tick_n(6);
        rc(A_PIN, 32'h2);
        rc(A_FLG, 32'h1);
        wr(A_CNT, 32'hFE);
        wr(A_FLG, 32'h3);
        tick_n(1);
        rc(A_PIN, 32'h2);
        tick_n(1);
        rc(A_CNT, 32'h00);
        rc(A_PIN, 32'h6);
        rc(A_FLG, 32'h2);
        tick_n(128);
        rc(A_PIN, 32'h6);
        tick_n(1);
        rc(A_PIN, 32'h2);
        wctl(1'b0, 2'h3, 2'h3);
        wr(A_CNT, 32'hFE);
        tick_n(2);
        rc(A_PIN, 32'h2);
        tick_n(129);
        rc(A_PIN, 32'h6);
        $display("test fast pwm done");
    endtask : t_fast

    // ==================================================================
    // main sequence and watchdog
    initial begin
        clock      = 1'b0;
        reset_n    = 1'b0;
        timer_tick = 1'b0;
        hsel       = 1'b0;
        haddr      = 8'h00;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h0;
        n_fail     = 0;
        num_checks = 0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_normal();
        t_ctc();
        t_force();
        t_block();
        t_fast();
        complete_run();
    end

    // whole run is under a thousand cycles; allow far more
    initial begin
        #500000;
        $display("watchdog expired");
        n_fail++;
        complete_run();
    end
endmodule : testbench
